// ===== shared/ssc_pkg.sv
// constants shared by the serial port status and control block
`default_nettype none

package ssc_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned INT_W  = 3;

	// ************************************************************
	// register byte addresses
	// ************************************************************
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_BUFFER   = 8'h04;
	localparam logic [7:0] ADDR_INT_STAT = 8'h08;
	localparam logic [7:0] ADDR_INT_MASK = 8'h0c;

	// ************************************************************
	// status and control register fields
	// ************************************************************
	localparam int unsigned BIT_PORT_ENABLE  = 15;
	localparam int unsigned BIT_HALT_IN_IDLE = 13;
	localparam int unsigned BIT_RX_OVERFLOW  = 6;
	localparam int unsigned BIT_TX_FULL      = 1;
	localparam int unsigned BIT_RX_FULL      = 0;

	// ************************************************************
	// interrupt status and mask fields
	// ************************************************************
	localparam int unsigned INT_RX_DONE  = 0;
	localparam int unsigned INT_TX_EMPTY = 1;
	localparam int unsigned INT_OVERFLOW = 2;

	// ************************************************************
	// reset values and counts
	// ************************************************************
	localparam logic        RST_FLAG     = 1'b0;
	localparam logic [15:0] RST_WORD     = 16'h0000;
	localparam logic [2:0]  RST_INT      = 3'h0;
	localparam logic [3:0]  RST_BIT_CNT  = 4'h0;
	localparam logic [3:0]  LAST_BIT_CNT = 4'hf;

endpackage : ssc_pkg

`default_nettype wire

// ===== src/ssc_sync.sv
// two-stage synchroniser for the link pins
`default_nettype none

module ssc_sync (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// asynchronous pins and their synchronised copies
	input  wire logic [2:0] pin_in,
	output logic      [2:0] pin_sync
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [2:0] stage1;
		logic [2:0] stage2;
	} ssc_sync_s;

	ssc_sync_s q;
	ssc_sync_s next_q;

	// stage1 feeds stage2 only, never any logic
	always_comb begin
		next_q        = q;
		next_q.stage1 = pin_in;
		next_q.stage2 = q.stage1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign pin_sync = q.stage2;

endmodule : ssc_sync

`default_nettype wire

// ===== src/ssc_shift.sv
// slave shift engine, mode 0, msb first, one 16-bit word per 16 clocks
`default_nettype none

module ssc_shift (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// control from the register side
	input  wire logic        run,
	input  wire logic [15:0] tx_word,
	// synchronised link
	input  wire logic        sck_s,
	input  wire logic        ss_n_s,
	input  wire logic        sdi_s,
	// events and data
	output logic             load,
	output logic             done,
	output logic      [15:0] rx_word,
	output logic             sdo,
	output logic             sdo_oe
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic        sck_d;
		logic        framed;
		logic        reload;
		logic [3:0]  cnt;
		logic [15:0] tx_sr;
		logic [15:0] rx_sr;
		logic        load;
		logic        done;
		logic [15:0] rx_word;
	} ssc_shift_s;

	ssc_shift_s q;
	ssc_shift_s next_q;
	logic       rise;
	logic       fall;

	always_comb begin
		next_q       = q;
		next_q.load  = 1'b0;
		next_q.done  = 1'b0;
		next_q.sck_d = sck_s;
		rise         = sck_s && !q.sck_d;
		fall         = !sck_s && q.sck_d;
		if (!run || ss_n_s) begin
			// a word cut short by deselect or halt is dropped
			next_q.framed = 1'b0;
			next_q.reload = 1'b0;
			next_q.cnt    = ssc_pkg::RST_BIT_CNT;
		end else if (!q.framed) begin
			next_q.framed = 1'b1;
			next_q.tx_sr  = tx_word;
			next_q.load   = 1'b1;
		end else if (rise) begin
			next_q.rx_sr = {q.rx_sr[14:0], sdi_s};
			if (q.cnt == ssc_pkg::LAST_BIT_CNT) begin
				next_q.cnt     = ssc_pkg::RST_BIT_CNT;
				next_q.done    = 1'b1;
				next_q.rx_word = {q.rx_sr[14:0], sdi_s};
				next_q.reload  = 1'b1;
			end else begin
				next_q.cnt = q.cnt + 4'h1;
			end
		end else if (fall) begin
			// the last falling edge of a word brings in the next one
			if (q.reload) begin
				next_q.tx_sr  = tx_word;
				next_q.load   = 1'b1;
				next_q.reload = 1'b0;
			end else begin
				next_q.tx_sr = {q.tx_sr[14:0], 1'b0};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign load    = q.load;
	assign done    = q.done;
	assign rx_word = q.rx_word;
	assign sdo     = q.tx_sr[15];
	assign sdo_oe  = q.framed;

endmodule : ssc_shift

`default_nettype wire

// ===== src/ssc_top.sv
// serial port status and control: apb registers, buffers, flags, interrupt
//
// Contract
// - enable bit runs port and claims output pin while selected
// - halt bit stops port while device idles
// - word into full receive buffer: drop, overflow
// - cpu buffer write loads transmit, sets full
// - move into shift register clears transmit full
// - word into receive buffer sets receive full
// - cpu buffer read returns word, clears full
// - unused status bits always read zero
`default_nettype none

module ssc_top (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// power state
	input  wire logic        device_idle,
	// serial link pins
	input  wire logic        serial_clock_pin,
	input  wire logic        slave_select_pin_n,
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin,
	output logic             serial_out_oe,
	// interrupt
	output logic             irq
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic        port_enable;
		logic        halt_in_idle;
		logic        rx_overflow_flag;
		logic        tx_buffer_full;
		logic        rx_buffer_full;
		logic [15:0] transmit_holding_buffer;
		logic [15:0] receive_holding_buffer;
		logic [2:0]  int_status;
		logic [2:0]  int_mask;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        irq;
		logic        sdo;
		logic        sdo_oe;
	} ssc_top_s;

	ssc_top_s    q;
	ssc_top_s    next_q;

	logic [2:0]  pin_sync;
	logic        run;
	logic [15:0] tx_word;
	logic        eng_load;
	logic        eng_done;
	logic [15:0] eng_rx_word;
	logic        eng_sdo;
	logic        eng_sdo_oe;

	logic        access;
	logic        commit;
	logic        wr;
	logic        rd;
	logic        mapped;
	logic [31:0] rdata;
	logic        link_sck;
	logic        link_ss_n;
	logic        link_sdi;

	logic        sel_status;
	logic        sel_buffer;
	logic        sel_int_stat;
	logic        sel_int_mask;
	logic        buf_rd;
	logic        buf_wr;
	logic        ctl_wr;
	logic        rx_store;
	logic        rx_drop;
	logic [2:0]  int_set;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	function automatic logic [31:0] half_word(input logic [15:0] v);
		half_word = {16'h0000, v};
	endfunction : half_word

	function automatic logic [31:0] event_word(input logic [2:0] v);
		event_word = {29'h0000_0000, v};
	endfunction : event_word

	function automatic logic [31:0] status_word(input ssc_top_s s);
		logic [31:0] w;
		w                             = 32'h0000_0000;
		w[ssc_pkg::BIT_PORT_ENABLE]   = s.port_enable;
		w[ssc_pkg::BIT_HALT_IN_IDLE]  = s.halt_in_idle;
		w[ssc_pkg::BIT_RX_OVERFLOW]   = s.rx_overflow_flag;
		w[ssc_pkg::BIT_TX_FULL]       = s.tx_buffer_full;
		w[ssc_pkg::BIT_RX_FULL]       = s.rx_buffer_full;
		status_word                   = w;
	endfunction : status_word

	// ************************************************************
	// link pins into the clock domain
	// ************************************************************
	ssc_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pin_in   ({serial_clock_pin, slave_select_pin_n, serial_in_pin}),
		.pin_sync (pin_sync)
	);

	assign link_sck  = pin_sync[2];
	assign link_ss_n = pin_sync[1];
	assign link_sdi  = pin_sync[0];

	// ************************************************************
	// shift engine
	// ************************************************************
	// idle only halts the port when the halt bit asks for it
	assign run     = q.port_enable && !(q.halt_in_idle && device_idle);
	// an empty transmit buffer sends zeros rather than stale data
	assign tx_word = q.tx_buffer_full ? q.transmit_holding_buffer : ssc_pkg::RST_WORD;

	ssc_shift u_shift (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (run),
		.tx_word (tx_word),
		.sck_s   (link_sck),
		.ss_n_s  (link_ss_n),
		.sdi_s   (link_sdi),
		.load    (eng_load),
		.done    (eng_done),
		.rx_word (eng_rx_word),
		.sdo     (eng_sdo),
		.sdo_oe  (eng_sdo_oe)
	);

	// ************************************************************
	// bus decode
	// ************************************************************
	always_comb begin
		access = psel && penable;
		commit = access && q.pready;
		wr     = commit && pwrite;
		rd     = commit && !pwrite;
		mapped = sel_status || sel_buffer || sel_int_stat || sel_int_mask;
		rdata  = 32'h0000_0000;
		if (sel_status) begin
			rdata = status_word(q);
		end else if (sel_buffer) begin
			rdata = half_word(q.receive_holding_buffer);
		end else if (sel_int_stat) begin
			rdata = event_word(q.int_status);
		end else if (sel_int_mask) begin
			rdata = event_word(q.int_mask);
		end
	end

	// ************************************************************
	// register selects and events
	// ************************************************************
	always_comb begin
		sel_status   = hit(paddr, ssc_pkg::ADDR_STATUS);
		sel_buffer   = hit(paddr, ssc_pkg::ADDR_BUFFER);
		sel_int_stat = hit(paddr, ssc_pkg::ADDR_INT_STAT);
		sel_int_mask = hit(paddr, ssc_pkg::ADDR_INT_MASK);
		buf_rd       = rd && sel_buffer;
		buf_wr       = wr && sel_buffer;
		ctl_wr       = wr && sel_status;
		// a read in this same cycle frees the buffer in time
		rx_drop      = eng_done && q.rx_buffer_full && !buf_rd;
		rx_store     = eng_done && !rx_drop;
		int_set                        = ssc_pkg::RST_INT;
		int_set[ssc_pkg::INT_RX_DONE]  = rx_store;
		int_set[ssc_pkg::INT_TX_EMPTY] = eng_load;
		int_set[ssc_pkg::INT_OVERFLOW] = rx_drop;
	end

	// ************************************************************
	// next state
	// ************************************************************
	// hardware clears go first and cpu sets after, then hardware
	// sets after cpu clears, so a set never loses to a clear
	always_comb begin
		next_q         = q;

		// bus answer, one cycle into the access phase
		next_q.pready  = access && !q.pready;
		next_q.prdata  = 32'h0000_0000;
		next_q.pslverr = 1'b0;
		if (access && !q.pready) begin
			next_q.prdata  = pwrite ? 32'h0000_0000 : rdata;
			next_q.pslverr = !mapped;
		end

		// transmit buffer handed to the shift register
		if (eng_load) begin
			next_q.tx_buffer_full                 = 1'b0;
		end

		// cpu read of the buffer empties the receive side
		if (buf_rd) begin
			next_q.rx_buffer_full = 1'b0;
		end

		// cpu writes
		if (ctl_wr) begin
			next_q.port_enable  = pwdata[ssc_pkg::BIT_PORT_ENABLE];
			next_q.halt_in_idle = pwdata[ssc_pkg::BIT_HALT_IN_IDLE];
			// writing one leaves overflow alone, only zero clears it
			if (!pwdata[ssc_pkg::BIT_RX_OVERFLOW]) begin
				next_q.rx_overflow_flag = 1'b0;
			end
		end
		if (buf_wr) begin
			next_q.transmit_holding_buffer = pwdata[15:0];
			next_q.tx_buffer_full          = 1'b1;
		end
		if (wr && sel_int_stat) begin
			next_q.int_status = q.int_status & ~pwdata[2:0];
		end
		if (wr && sel_int_mask) begin
			next_q.int_mask = pwdata[2:0];
		end

		// hardware events come after the cpu clears, so a set wins
		next_q.int_status = next_q.int_status | int_set;
		if (rx_drop) begin
			next_q.rx_overflow_flag = 1'b1;
		end
		if (rx_store) begin
			next_q.receive_holding_buffer = eng_rx_word;
			next_q.rx_buffer_full         = 1'b1;
		end

		// interrupt level and pin outputs, all registered
		next_q.irq    = |(next_q.int_status & next_q.int_mask);
		next_q.sdo    = eng_sdo;
		next_q.sdo_oe = eng_sdo_oe && run;
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.port_enable             <= ssc_pkg::RST_FLAG;
			q.halt_in_idle            <= ssc_pkg::RST_FLAG;
			q.rx_overflow_flag        <= ssc_pkg::RST_FLAG;
			q.tx_buffer_full          <= ssc_pkg::RST_FLAG;
			q.rx_buffer_full          <= ssc_pkg::RST_FLAG;
			q.transmit_holding_buffer <= ssc_pkg::RST_WORD;
			q.receive_holding_buffer  <= ssc_pkg::RST_WORD;
			q.int_status              <= ssc_pkg::RST_INT;
			q.int_mask                <= ssc_pkg::RST_INT;
			q.pready                  <= 1'b0;
			q.pslverr                 <= 1'b0;
			q.prdata                  <= 32'h0000_0000;
			q.irq                     <= 1'b0;
			q.sdo                     <= 1'b0;
			q.sdo_oe                  <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign prdata         = q.prdata;
	assign pready         = q.pready;
	assign pslverr        = q.pslverr;
	assign serial_out_pin = q.sdo;
	assign serial_out_oe  = q.sdo_oe;
	assign irq            = q.irq;

endmodule : ssc_top

`default_nettype wire

// ===== sim/ssc_checker.sv
// port assertions for the serial port status and control block
`default_nettype none

module ssc_checker (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// power, link, interrupt
	input wire logic        device_idle,
	input wire logic        serial_clock_pin,
	input wire logic        slave_select_pin_n,
	input wire logic        serial_in_pin,
	input wire logic        serial_out_pin,
	input wire logic        serial_out_oe,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ******
	// shadows of software writes and status reads
	// ******
	logic       done;
	logic       st_acc;
	logic       en_q;
	logic       halt_q;
	logic       ovf_q;
	logic [2:0] mask_q;
	assign done   = psel && penable && pready;
	assign st_acc = done && paddr == ssc_pkg::ADDR_STATUS;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q   <= 1'b0;
			halt_q <= 1'b0;
			ovf_q  <= 1'b0;
			mask_q <= 3'h0;
		end else begin
			if (st_acc && pwrite) begin
				en_q   <= pwdata[15];
				halt_q <= pwdata[13];
			end
			if (done && pwrite && paddr == ssc_pkg::ADDR_INT_MASK)
				mask_q <= pwdata[2:0];
			// set beats a write of zero, so only a seen read may arm it
			if (st_acc)
				ovf_q <= pwrite ? (ovf_q && pwdata[6]) : prdata[6];
		end
	end

	ready_pulse_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("pready is not a single pulse");
	idle_data_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data outside answer cycle");
	unused_zero_a: assert property (st_acc && !pwrite |-> prdata[31:16] == 16'h0
		&& !prdata[14] && prdata[12:7] == 6'h0 && prdata[5:2] == 4'h0)
		else $error("unused status bit set");
	unmapped_err_a: assert property (done && paddr[7:4] != 4'h0 |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	ovf_sticky_a: assert property (st_acc && !pwrite && ovf_q |-> prdata[6])
		else $error("overflow cleared without software");
	oe_enable_a: assert property ((!en_q)[*8] |-> !serial_out_oe)
		else $error("output driven while disabled");
	oe_halt_a: assert property ((halt_q && device_idle)[*8] |-> !serial_out_oe)
		else $error("output driven while halted");
	oe_claim_a: assert property ($rose(serial_out_oe) |-> en_q && !$past(slave_select_pin_n, 3))
		else $error("output claimed without select");
	irq_mask_a: assert property ((mask_q == 3'h0)[*2] |-> !irq)
		else $error("irq with all events masked");

	cover property (st_acc && !pwrite && prdata[6]);
	cover property ($rose(irq));
	cover property ($rose(serial_out_oe));
endmodule : ssc_checker

bind ssc_top ssc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .device_idle(device_idle),
	.serial_clock_pin(serial_clock_pin), .slave_select_pin_n(slave_select_pin_n),
	.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
	.serial_out_oe(serial_out_oe), .irq(irq));

`default_nettype wire

// ===== sim/ssc_far_master.sv
// remote spi master, mode 0, 16-bit words, msb first
`default_nettype none

module ssc_far_master (
	// link
	output logic      sck,
	output logic      ss_n,
	output logic      mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sck  = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end
	// miso taken late in the high phase: the slave shifts up to 4 pclk after the fall
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		ss_n = 1'b0;
		#230;
		for (int i = 15; i >= 0; i--) begin
			mosi = tx[i];
			#80 sck = 1'b1;
			#77 rx[i] = miso_oe ? miso : 1'bx;
			#3 sck = 1'b0;
		end
		#100 ss_n = 1'b1;
		// released line: inverse, never the last value
		mosi = ~mosi;
		#300;
	endtask : xfer
endmodule : ssc_far_master

`default_nettype wire

// ===== sim/tb_spi_status_control.sv
// self-checking bench for the serial port status and control block
`default_nettype none

module tb_spi_status_control;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, device_idle;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        sck, ss_n, mosi, miso, miso_oe, irq, err;
	logic [15:0] got, txw, rxw;
	int          fail_count, check_count;

	ssc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .device_idle(device_idle), .serial_clock_pin(sck),
		.slave_select_pin_n(ss_n), .serial_in_pin(mosi), .serial_out_pin(miso),
		.serial_out_oe(miso_oe), .irq(irq));
	ssc_far_master u_far (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	function automatic logic [31:0] st(input logic en, hlt, ovf, tbf, rbf);
		return {16'h0, en, 1'b0, hlt, 6'h0, ovf, 4'h0, tbf, rbf};
	endfunction : st

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		check(nm, rd, exp);
	endtask : rdchk

	task automatic irq_step(input logic [7:0] a, input logic [31:0] d, input logic exp);
		apb(1'b1, a, d);
		repeat (2) @(posedge pclk);
		check("irq", {31'h0, irq}, {31'h0, exp});
	endtask : irq_step

	initial begin
		{psel, penable, pwrite, paddr, pwdata, device_idle} = '0;
		presetn = 1'b0;
		void'($urandom(32'h69be2c3b));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(ssc_pkg::ADDR_STATUS, st(0, 0, 0, 0, 0), "status reset");
		rdchk(ssc_pkg::ADDR_INT_MASK, 32'h0, "mask reset");
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped", {err, rd[30:0]}, 32'h80000000);
		apb(1'b1, ssc_pkg::ADDR_STATUS, 32'hffffffff);
		rdchk(ssc_pkg::ADDR_STATUS, st(1, 1, 0, 0, 0), "status rw");
		apb(1'b1, ssc_pkg::ADDR_STATUS, st(1, 0, 0, 0, 0));
		repeat (3) begin
			txw = 16'($urandom);
			rxw = 16'($urandom);
			apb(1'b1, ssc_pkg::ADDR_BUFFER, {16'h0, txw});
			rdchk(ssc_pkg::ADDR_STATUS, st(1, 0, 0, 1, 0), "tx full");
			u_far.xfer(rxw, got);
			check("miso word", {16'h0, got}, {16'h0, txw});
			rdchk(ssc_pkg::ADDR_STATUS, st(1, 0, 0, 0, 1), "rx full");
			rdchk(ssc_pkg::ADDR_INT_STAT, 32'h3, "events");
			apb(1'b1, ssc_pkg::ADDR_INT_STAT, 32'h3);
			rdchk(ssc_pkg::ADDR_BUFFER, {16'h0, rxw}, "rx word");
			rdchk(ssc_pkg::ADDR_STATUS, st(1, 0, 0, 0, 0), "rx read");
		end
		apb(1'b1, ssc_pkg::ADDR_INT_MASK, 32'h4);
		u_far.xfer(16'h8001, got);
		check("empty tx", {16'h0, got}, 32'h0);
		u_far.xfer(16'h7ffe, got);
		rdchk(ssc_pkg::ADDR_STATUS, st(1, 0, 1, 0, 1), "overflow");
		check("irq", {31'h0, irq}, 32'h1);
		rdchk(ssc_pkg::ADDR_BUFFER, 32'h8001, "kept word");
		apb(1'b1, ssc_pkg::ADDR_STATUS, st(1, 0, 1, 0, 0));
		rdchk(ssc_pkg::ADDR_STATUS, st(1, 0, 1, 0, 0), "ovf sticky");
		apb(1'b1, ssc_pkg::ADDR_STATUS, st(1, 0, 0, 0, 0));
		rdchk(ssc_pkg::ADDR_STATUS, st(1, 0, 0, 0, 0), "ovf cleared");
		irq_step(ssc_pkg::ADDR_INT_MASK, 32'h0, 1'b0);
		irq_step(ssc_pkg::ADDR_INT_MASK, 32'h4, 1'b1);
		irq_step(ssc_pkg::ADDR_INT_STAT, 32'h4, 1'b0);
		// disabled, halted in idle, halt bit set but awake, idle without halt
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, ssc_pkg::ADDR_STATUS, st(i > 0, i == 1 || i == 2, 0, 0, 0));
			device_idle <= (i == 1 || i == 3);
			rxw = 16'($urandom);
			u_far.xfer(rxw, got);
			rdchk(ssc_pkg::ADDR_STATUS, st(i > 0, i == 1 || i == 2, 0, 0, i > 1), "gated");
			apb(1'b0, ssc_pkg::ADDR_BUFFER, 32'h0);
			if (i > 1)
				check("gated word", rd, {16'h0, rxw});
		end
		device_idle <= 1'b0;
		summarize();
	end
endmodule : tb_spi_status_control

`default_nettype wire
